//--- design/aoc_pkg.sv
/*
 * Shared constants and carrier types for the converter output test and ready control block.
 * Assumes one 100 MHz sampling clock and a 32-bit Avalon-MM register bus.
 */
package aoc_pkg;

	// ------------------------------------------------------------
	// word and timing
	// ------------------------------------------------------------
	localparam int unsigned WORD_W = 10;
	localparam int unsigned DECIM_RATIO = 32;
	localparam int unsigned DECIM_W = $clog2(DECIM_RATIO);
	localparam logic [DECIM_W-1:0] DECIM_LAST = DECIM_W'(DECIM_RATIO - 1);
	localparam logic [DECIM_W-1:0] DECIM_ZERO = '0;
	localparam logic [WORD_W-1:0] CHECKER_A = 10'h155;
	localparam logic [WORD_W-1:0] CHECKER_B = 10'h2aa;
	localparam logic [WORD_W-1:0] WORD_ZERO = '0;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_WORDS = 4'h8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] WORDS_RESET = 32'h0000_0000;
	localparam int unsigned CTRL_PATTERN_BIT = 0;
	localparam int unsigned CTRL_DECIM_BIT = 1;
	localparam int unsigned CTRL_HOLD_BIT = 2;
	localparam int unsigned STAT_DECIM_BIT = 0;
	localparam int unsigned STAT_PATTERN_BIT = 1;
	localparam int unsigned STAT_GRAY_BIT = 2;
	localparam int unsigned STAT_HELD_BIT = 3;
	localparam int unsigned STAT_DELAY_BIT = 4;
	localparam int unsigned STAT_PHASE_BIT = 5;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	// strap pins, each at its electrical level (1 = floating/ground, 0 = low/negative supply)
	typedef struct packed {
		logic diode_test;
		logic pattern_select;
		logic output_code_select;
		logic ready_strobe_reset;
		logic delay_enable_jumper;
	} aoc_pins_s;

	localparam aoc_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

	typedef struct packed {
		logic decimate;
		logic pattern;
		logic gray;
	} aoc_mode_s;

	typedef enum logic [1:0] {
		AOC_RDY_RUN,
		AOC_RDY_HELD
	} aoc_rdy_e;

endpackage

//--- design/aoc_word_coder.sv
/*
 * Output word former: checkerboard generator, binary or Gray coding, output word register.
 * Assumes advance_in is a one-cycle strobe on clk_sys_in marking each word that leaves.
 */
`timescale 1ns/100ps
module aoc_word_coder (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// control
	input wire logic advance_in,
	input wire aoc_pkg::aoc_mode_s mode_in,
	input wire logic [aoc_pkg::WORD_W-1:0] sample_in,
	// result
	output logic [aoc_pkg::WORD_W-1:0] word_out,
	output logic phase_out
);
	import aoc_pkg::*;

	logic phase;
	logic next_phase;
	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] next_word;

	function automatic logic [WORD_W-1:0] to_gray(input logic [WORD_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	always_comb begin
		next_phase = phase;
		next_word = word;
		if (advance_in) begin
			if (mode_in.pattern) begin
				next_word = phase ? CHECKER_B : CHECKER_A; // RULE3
				next_phase = ~phase; // RULE12
			end else if (mode_in.gray) begin
				next_word = to_gray(sample_in); // RULE10
			end else begin
				next_word = sample_in; // RULE4
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			phase <= 1'b0;
			word <= WORD_ZERO;
		end else begin
			phase <= next_phase;
			word <= next_word;
		end
	end

	// bit 0 is the least significant bit, bit 9 the most
	assign word_out = word; // RULE11
	assign phase_out = phase;

endmodule

//--- design/aoc_output_ctrl.sv
/*
 * Output port control of a 10-bit sampling converter: decimation, checkerboard test words,
 * binary/Gray coding, data-ready strobe with its reset input, sampling delay enable,
 * and an Avalon-MM register slave.
 * Assumes clk_sys_in is the free-running sampling clock and sample_in comes from logic on it;
 * strap pins are asynchronous and are synchronised here.
 */
// What this block does
// RULE1 - with decimation active only one sample in 32 leaves the port
// RULE2 - outside party pulls the diode/test pin to the negative supply for decimation
// RULE3 - pattern select low: checkerboard words replace the digitised samples
// RULE4 - pattern select floating or grounded: digitised samples leave, coded per code select; here ctrl bit CTRL_PATTERN_BIT still forces checkerboard words
// RULE5 - falling edge of the ready reset input forces the ready strobe to zero
// RULE6 - while ready reset stays low the ready strobe stays zero
// RULE7 - ready strobe resumes toggling from the rising edge of ready reset
// RULE8 - ready reset grounded or floating: ready strobe runs freely; here ctrl bit CTRL_HOLD_BIT still holds the strobe at zero
// RULE9 - delay jumper floating/grounded disables sample delay; negative supply enables it
// RULE10 - code select floating/grounded gives binary words; negative supply gives Gray
// RULE11 - each word is 10 bits parallel, bit 0 least, bit 9 most significant
// RULE12 - checkerboard words alternate between complements so every bit toggles per word
`timescale 1ns/100ps
module aoc_output_ctrl (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// avalon-mm slave
	input wire logic [aoc_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// strap pins and sample stream
	input wire aoc_pkg::aoc_pins_s pins_in,
	input wire logic [aoc_pkg::WORD_W-1:0] sample_in,
	// output port
	output logic [aoc_pkg::WORD_W-1:0] data_word_out,
	output logic ready_strobe_out,
	output logic sample_instant_delay_enable_out
);
	import aoc_pkg::*;

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	aoc_pins_s pins_s1;
	aoc_pins_s pins_s2;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			pins_s1 <= PINS_IDLE;
			pins_s2 <= PINS_IDLE;
		end else begin
			pins_s1 <= pins_in;
			pins_s2 <= pins_s1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [31:0] words;
	logic [31:0] next_words;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic ack;
	logic next_ack;
	logic phase;

	aoc_mode_s mode;
	logic advance;
	logic ready_ok;

	// a low strap level selects each test function; software may force two of them
	assign mode.decimate = ~pins_s2.diode_test | ctrl[CTRL_DECIM_BIT]; // RULE2
	assign mode.pattern = ~pins_s2.pattern_select | ctrl[CTRL_PATTERN_BIT];
	assign mode.gray = ~pins_s2.output_code_select; // RULE10
	// software hold acts like a held-low ready reset
	assign ready_ok = pins_s2.ready_strobe_reset & ~ctrl[CTRL_HOLD_BIT];

	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] status_word(input aoc_mode_s m, input logic held,
		input logic dly, input logic ph);
		logic [31:0] s;
		s = '0;
		s[STAT_DECIM_BIT] = m.decimate;
		s[STAT_PATTERN_BIT] = m.pattern;
		s[STAT_GRAY_BIT] = m.gray;
		s[STAT_HELD_BIT] = held;
		s[STAT_DELAY_BIT] = dly;
		s[STAT_PHASE_BIT] = ph;
		return s;
	endfunction

	// one wait state: request seen, answer in the next cycle
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
	assign avs_readdata_out = rdata;

	always_comb begin
		next_ack = (avs_read_in | avs_write_in) & ~ack;
		next_ctrl = ctrl;
		next_rdata = rdata;
		next_words = advance ? words + 32'h0000_0001 : words;
		if (next_ack && avs_write_in && avs_address_in == REG_CTRL) begin
			next_ctrl = byte_merge(ctrl, avs_writedata_in, avs_byteenable_in);
		end
		if (next_ack && avs_read_in) begin
			unique case (avs_address_in)
				REG_CTRL: next_rdata = ctrl;
				REG_STATUS: next_rdata = status_word(mode, ~ready_ok,
					sample_instant_delay_enable_out, phase);
				REG_WORDS: next_rdata = words;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		// writing the word counter clears it; a concurrent word is dropped from the count
		if (next_ack && avs_write_in && avs_address_in == REG_WORDS) begin
			next_words = WORDS_RESET;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ack <= 1'b0;
			ctrl <= CTRL_RESET;
			rdata <= 32'h0000_0000;
			words <= WORDS_RESET;
		end else begin
			ack <= next_ack;
			ctrl <= next_ctrl;
			rdata <= next_rdata;
			words <= next_words;
		end
	end

	// ------------------------------------------------------------
	// decimation
	// ------------------------------------------------------------
	logic [DECIM_W-1:0] dec_cnt;
	logic [DECIM_W-1:0] next_dec_cnt;

	// count rests at zero outside decimation, so entry always waits a full 32 samples
	assign advance = ~mode.decimate | (dec_cnt == DECIM_LAST); // RULE1

	always_comb begin
		next_dec_cnt = DECIM_ZERO;
		if (mode.decimate) begin
			next_dec_cnt = dec_cnt + DECIM_W'(1); // RULE1
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			dec_cnt <= DECIM_ZERO;
		end else begin
			dec_cnt <= next_dec_cnt;
		end
	end

	// ------------------------------------------------------------
	// word former
	// ------------------------------------------------------------
	aoc_word_coder u_coder (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.advance_in(advance),
		.mode_in(mode),
		.sample_in(sample_in),
		.word_out(data_word_out),
		.phase_out(phase)
	);

	// ------------------------------------------------------------
	// ready strobe
	// ------------------------------------------------------------
	aoc_rdy_e rdy_state;
	aoc_rdy_e next_rdy_state;
	logic ready;
	logic next_ready;
	logic delay_en;
	logic next_delay_en;

	always_comb begin
		next_rdy_state = rdy_state;
		next_ready = ready;
		unique case (rdy_state)
			AOC_RDY_RUN: begin
				if (!ready_ok) begin
					next_rdy_state = AOC_RDY_HELD;
					next_ready = 1'b0; // RULE5
				end else if (advance) begin
					next_ready = ~ready; // RULE8
				end
			end
			// held: strobe stays low whatever the sampling clock does
			AOC_RDY_HELD: begin
				next_ready = 1'b0; // RULE6
				if (ready_ok) begin
					next_rdy_state = AOC_RDY_RUN;
					next_ready = advance; // RULE7
				end
			end
			default: begin
				next_rdy_state = AOC_RDY_RUN;
				next_ready = 1'b0;
			end
		endcase
		next_delay_en = ~pins_s2.delay_enable_jumper; // RULE9
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			rdy_state <= AOC_RDY_RUN;
			ready <= 1'b0;
			delay_en <= 1'b0;
		end else begin
			rdy_state <= next_rdy_state;
			ready <= next_ready;
			delay_en <= next_delay_en;
		end
	end

	assign ready_strobe_out = ready;
	assign sample_instant_delay_enable_out = delay_en;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence s_pat_word;
		mode.pattern && advance;
	endsequence

	sequence s_two_pat_words;
		s_pat_word ##1 s_pat_word;
	endsequence

	sequence s_hold_gap;
		!ready_ok ##1 !ready_ok;
	endsequence

	a_decim_one_in: assert property (mode.decimate && advance |-> dec_cnt == DECIM_LAST) // RULE1
		else $error("decimated word left off the 32nd count");
	a_decim_gap: assert property ((mode.decimate && advance) ##1 mode.decimate |-> !advance) // RULE1
		else $error("two decimated words in a row");
	a_pattern_word: assert property (s_pat_word |=>
		(data_word_out == CHECKER_A || data_word_out == CHECKER_B)) // RULE3
		else $error("pattern mode word is not a checkerboard");
	a_checker_flip: assert property (s_two_pat_words |=>
		data_word_out == ~$past(data_word_out)) // RULE12
		else $error("checkerboard words did not complement");
	a_binary_pass: assert property (!mode.pattern && !mode.gray && advance |=>
		data_word_out == $past(sample_in)) // RULE4
		else $error("binary word differs from sample");
	a_gray_code: assert property (!mode.pattern && mode.gray && advance |=>
		data_word_out == ($past(sample_in) ^ ($past(sample_in) >> 1))) // RULE10
		else $error("gray word wrong");
	a_ready_fall: assert property ($fell(ready_ok) |=> !ready_strobe_out) // RULE5
		else $error("ready strobe not cleared on reset fall");
	a_ready_held: assert property (s_hold_gap |-> !ready_strobe_out) // RULE6
		else $error("ready strobe moved while held");
	a_ready_resume: assert property ($rose(ready_ok) && advance |=> ready_strobe_out) // RULE7
		else $error("ready strobe did not restart");
	a_ready_free: assert property (ready_ok && $past(ready_ok) && advance |=>
		ready_strobe_out != $past(ready_strobe_out)) // RULE8
		else $error("ready strobe failed to toggle");
	a_delay_enable: assert property (##1 (sample_instant_delay_enable_out ==
		~$past(pins_s2.delay_enable_jumper))) // RULE9
		else $error("delay enable does not follow jumper");

	// a decimated word and its strobe must stand for the whole gap
	a_word_stands: assert property (!advance |=> $stable(data_word_out)) // RULE1
		else $error("output word changed between advances");
	a_strobe_stands: assert property (ready_ok && !advance |=> $stable(ready_strobe_out)) // RULE1
		else $error("ready strobe moved between advances");
	a_hold_quiet: assert property (ctrl[CTRL_HOLD_BIT] |=> !ready_strobe_out) // RULE6
		else $error("software hold let the ready strobe move");
	a_decim_rearm: assert property (!mode.decimate |=> dec_cnt == DECIM_ZERO) // RULE1
		else $error("decimation count not rearmed");
	// the word counter moves only with a leaving word or a software write
	a_words_step: assert property (!advance && !avs_write_in |=> words == $past(words))
		else $error("word counter moved with no word");
	a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=>
		!avs_waitrequest_out)
		else $error("bus request waited more than one cycle");

endmodule

//--- tb/aoc_capture_model.sv
/*
 * Capture-side model of the converter output port: counts words, keeps the last one and the gap.
 * Assumes the ready strobe toggles once per output word, both edges mark a word.
 */
`timescale 1ns/100ps
module aoc_capture_model
	import aoc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// converter output port
	input wire logic [aoc_pkg::WORD_W-1:0] data_word_in,
	input wire logic ready_strobe_in,
	// capture results
	output logic [15:0] words_out,
	output logic [aoc_pkg::WORD_W-1:0] last_word_out,
	output logic [7:0] gap_out
);
	logic prev;
	logic [7:0] run;

	// either strobe edge takes a word, so a stuck strobe shows as a frozen count
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			prev <= 1'b0;
			run <= 8'h00;
			words_out <= 16'h0000;
			last_word_out <= WORD_ZERO;
			gap_out <= 8'h00;
		end else if (ready_strobe_in !== prev) begin
			prev <= ready_strobe_in;
			run <= 8'h01;
			gap_out <= run;
			words_out <= words_out + 16'h0001;
			last_word_out <= data_word_in;
		end else begin
			run <= run + 8'h01;
		end
	end
endmodule

//--- tb/adc_output_test_and_ready_control_test.sv
/*
 * Self-checking bench for the converter output control block, with an Avalon-MM master.
 * Assumes the design's package and the capture model are compiled first.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %h expected %h", $time, g, e); end end
module adc_output_test_and_ready_control_test;
	import aoc_pkg::*;
	logic clk_sys_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [ADDR_W-1:0] avs_address_in = '0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = '0;
	logic [3:0] avs_byteenable_in = 4'hf;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	aoc_pins_s pins_in = PINS_IDLE;
	logic [WORD_W-1:0] sample_in = 10'h2c5;
	logic [WORD_W-1:0] data_word_out;
	logic ready_strobe_out;
	logic sample_instant_delay_enable_out;
	logic [15:0] words_out;
	logic [WORD_W-1:0] last_word_out;
	logic [7:0] gap_out;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [WORD_W-1:0] samples [4] = '{10'h001, 10'h200, 10'h2c5, 10'h3ff};
	logic [WORD_W-1:0] w;
	logic [31:0] q;
	logic [15:0] n;

	aoc_output_ctrl i_dut (.clk_sys_in, .sys_rst_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .pins_in, .sample_in, .data_word_out, .ready_strobe_out,
		.sample_instant_delay_enable_out);
	aoc_capture_model i_cap (.clk_sys_in, .sys_rst_in, .data_word_in(data_word_out),
		.ready_strobe_in(ready_strobe_out), .words_out, .last_word_out, .gap_out);

	always #5 clk_sys_in = ~clk_sys_in;

	// ------------------------------------------------------------
	// bus and timing tasks
	// ------------------------------------------------------------
	// waitrequest is sampled at the rising edge that completes the request
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys_in);
		avs_address_in <= a;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		avs_writedata_in <= d;
		do begin
			@(posedge clk_sys_in);
			k++;
		end while (avs_waitrequest_out !== 1'b0 && k < 50);
		if (k >= 50) miscompares++;
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		@(negedge clk_sys_in);
		`CHK(ready_strobe_out, 1'b0)
		`CHK(sample_instant_delay_enable_out, 1'b0)
		bus(1'b0, REG_CTRL, 32'h0);
		`CHK(q, CTRL_RESET)
		// unmapped place: writes vanish, reads give zero
		bus(1'b1, 4'hc, 32'hffff_ffff);
		bus(1'b0, 4'hc, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b0, REG_CTRL, 32'h0);
		`CHK(q, CTRL_RESET)
		foreach (samples[i]) begin
			@(posedge clk_sys_in) sample_in <= samples[i];
			settle(4);
			`CHK(data_word_out, samples[i])
			`CHK(last_word_out, samples[i])
			`CHK(gap_out, 8'h01)
		end
		@(posedge clk_sys_in) pins_in.output_code_select <= 1'b0;
		foreach (samples[i]) begin
			@(posedge clk_sys_in) sample_in <= samples[i];
			settle(5);
			`CHK(data_word_out, samples[i] ^ (samples[i] >> 1))
		end
		bus(1'b0, REG_STATUS, 32'h0);
		`CHK(q[STAT_GRAY_BIT], 1'b1)
		pins_in.output_code_select <= 1'b1;
		pins_in.pattern_select <= 1'b0;
		settle(5);
		w = data_word_out;
		`CHK((w === CHECKER_A) || (w === CHECKER_B), 1'b1)
		settle(0);
		`CHK(data_word_out, ~w)
		@(posedge clk_sys_in) pins_in.pattern_select <= 1'b1;
		settle(5);
		`CHK(data_word_out, sample_in)
		// register-forced pattern must look the same as the strap
		bus(1'b1, REG_CTRL, 32'h1);
		settle(3);
		`CHK((data_word_out === CHECKER_A) || (data_word_out === CHECKER_B), 1'b1)
		bus(1'b1, REG_CTRL, 32'h0);
		pins_in.ready_strobe_reset <= 1'b0;
		settle(4);
		n = words_out;
		`CHK(ready_strobe_out, 1'b0)
		settle(10);
		`CHK(ready_strobe_out, 1'b0)
		`CHK(words_out, n)
		@(posedge clk_sys_in) pins_in.ready_strobe_reset <= 1'b1;
		settle(6);
		`CHK(words_out > n, 1'b1)
		`CHK(gap_out, 8'h01)
		bus(1'b1, REG_CTRL, 32'h4);
		settle(3);
		n = words_out;
		settle(5);
		`CHK(words_out, n)
		bus(1'b0, REG_STATUS, 32'h0);
		`CHK(q[STAT_HELD_BIT], 1'b1)
		bus(1'b1, REG_CTRL, 32'h0);
		pins_in.diode_test <= 1'b0;
		settle(110);
		`CHK(gap_out, 8'(DECIM_RATIO))
		bus(1'b0, REG_STATUS, 32'h0);
		`CHK(q[STAT_DECIM_BIT], 1'b1)
		pins_in.diode_test <= 1'b1;
		pins_in.delay_enable_jumper <= 1'b0;
		settle(5);
		`CHK(sample_instant_delay_enable_out, 1'b1)
		@(posedge clk_sys_in) pins_in.delay_enable_jumper <= 1'b1;
		settle(5);
		`CHK(sample_instant_delay_enable_out, 1'b0)
		// register-forced decimation must thin the stream like the strap
		bus(1'b1, REG_CTRL, 32'h2);
		settle(70);
		`CHK(gap_out, 8'(DECIM_RATIO))
		bus(1'b0, REG_STATUS, 32'h0);
		`CHK(q[STAT_DECIM_BIT], 1'b1)
		bus(1'b1, REG_CTRL, 32'h0);
		bus(1'b1, REG_WORDS, 32'h0);
		bus(1'b0, REG_WORDS, 32'h0);
		`CHK(q < 32'h10, 1'b1)
		summarize();
	end
endmodule
